// ===== src/fmrcb_pkg.sv
// ************************************************************
// register map and field layout
// ************************************************************
package fmrcb_pkg;

	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned NUM_CH  = 4;
	localparam int unsigned NUM_FLT = 8;

	localparam logic [7:0] REVERSE_BLOCK_GATE_CONFIG_OFS = 8'h26;
	localparam logic [7:0] FAULT_PIN_SUPPRESS_CONFIG_OFS = 8'h27;
	localparam logic [7:0] OFFSTATE_OPEN_LOAD_ENABLE_OFS = 8'h28;
	// fault-type status lives outside the three config registers
	localparam logic [7:0] FAULT_TYPE_STATUS_OFS         = 8'h10;

	localparam logic [7:0] REVERSE_BLOCK_GATE_CONFIG_RST = 8'h0f;
	localparam logic [7:0] FAULT_PIN_SUPPRESS_CONFIG_RST = 8'h00;
	localparam logic [7:0] OFFSTATE_OPEN_LOAD_ENABLE_RST = 8'h00;
	localparam logic [7:0] FAULT_TYPE_STATUS_RST         = 8'h00;

	// only bits 3..0 are defined in the per-channel registers
	localparam logic [7:0] CHANNEL_FIELD_MASK = 8'h0f;
	localparam logic [7:0] FULL_FIELD_MASK    = 8'hff;
	localparam logic [7:0] READ_ZERO          = 8'h00;

	// bit positions shared by mask register and status register
	localparam int unsigned BIT_SPI_ERR   = 7;
	localparam int unsigned BIT_WATCHDOG_TIMEOUT_ERROR    = 6;
	localparam int unsigned BIT_ILIMIT    = 5;
	localparam int unsigned BIT_REVERSE   = 4;
	localparam int unsigned BIT_SHORT_VS  = 3;
	localparam int unsigned BIT_WB_OFF    = 2;
	localparam int unsigned BIT_WB_ON     = 1;
	localparam int unsigned BIT_UNDERVOLT = 0;

	typedef struct packed {
		logic                spi_error;
		logic                watchdog_timeout_error;
		logic                current_limit;
		logic                reverse_current;
		logic                short_supply;
		logic                offstate_open;
		logic                onstate_open;
		logic                undervoltage;
	} fmrcb_fault_s;

	typedef struct packed {
		logic                wr;
		logic                rd;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
	} fmrcb_req_s;

	typedef struct packed {
		logic                valid;
		logic [DATA_W-1:0]   rdata;
	} fmrcb_rsp_s;

endpackage

// ===== src/fmrcb_sticky_flag.sv
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// one fault flag: latched until read, or follows the condition
// ************************************************************
module fmrcb_sticky_flag (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic cond,
	input  wire logic clr,
	input  wire logic latch_dis,
	output var  logic flag
);

	logic flag_reg;
	logic flag_next;

	always_comb begin
		if (latch_dis) begin
			flag_next = cond;
		end else begin
			// set wins so an event in the read cycle is kept
			flag_next = cond | (flag_reg & ~clr);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag = flag_reg;

endmodule

`default_nettype wire

// ===== src/fmrcb_regs.sv
// What this block does
// - per channel, 0 selects gate pulldown, 1 selects blocking, unless globally disabled.
// - reverse-block register resets to 0fh; bits 3..0 are channels 4..1.
// - mask bit 7 keeps SPI errors off the fault pin, status still records.
// - mask bit 5 keeps current-limit events off the fault pin.
// - mask bit 4 keeps reverse-current faults off the fault pin.
// - mask bit 3 keeps off-state short-to-supply faults off the fault pin.
// - mask bit 2 keeps off-state wire-break faults off the fault pin.
// - mask bit 1 keeps on-state wire-break faults off the fault pin.
// - mask bit 0 keeps supply undervoltage faults off the fault pin.
// - fault mask register resets to 00h, so every fault flagged in status reaches the pin.
// - off-state wire-break enable resets 00h; cleared bit keeps channel fault out.
// - latched fault bits stay set until read, unless latching is disabled.
`timescale 1ns/10ps
`default_nettype none

module fmrcb_regs (
	input  wire logic                         CLK_SYS,
	input  wire logic                         NRST,
	input  wire fmrcb_pkg::fmrcb_req_s        REG_REQ,
	output var  fmrcb_pkg::fmrcb_rsp_s        REG_RSP,
	input  wire logic                         GLOBAL_REV_BLOCK_DISABLE,
	input  wire logic                         FAULT_LATCH_DISABLE,
	input  wire fmrcb_pkg::fmrcb_fault_s      FAULT_RAW,
	input  wire logic [fmrcb_pkg::NUM_CH-1:0] OFFSTATE_OPEN_RAW,
	output var  logic [fmrcb_pkg::NUM_CH-1:0] REV_BLOCK_ENABLE,
	output var  logic [fmrcb_pkg::NUM_CH-1:0] REV_BLOCK_PULLDOWN,
	output var  logic [fmrcb_pkg::NUM_CH-1:0] OFFSTATE_OPEN_DIAG_EN,
	output var  logic                         FAULT_INDICATOR_PIN_O,
	output var  logic                         FAULT_INDICATOR_PIN_OE
);

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic [7:0] rev_block_reg;
	logic [7:0] rev_block_next;
	logic [7:0] suppress_reg;
	logic [7:0] suppress_next;
	logic [7:0] open_en_reg;
	logic [7:0] open_en_next;

	logic wr_rev;
	logic wr_sup;
	logic wr_open;

	// the status offset decodes no write: it is read-only
	assign wr_rev  = REG_REQ.wr && (REG_REQ.addr == fmrcb_pkg::REVERSE_BLOCK_GATE_CONFIG_OFS);
	assign wr_sup  = REG_REQ.wr && (REG_REQ.addr == fmrcb_pkg::FAULT_PIN_SUPPRESS_CONFIG_OFS);
	assign wr_open = REG_REQ.wr && (REG_REQ.addr == fmrcb_pkg::OFFSTATE_OPEN_LOAD_ENABLE_OFS);

	always_comb begin
		rev_block_next = rev_block_reg;
		suppress_next  = suppress_reg;
		open_en_next   = open_en_reg;
		if (wr_rev) begin
			rev_block_next = REG_REQ.wdata & fmrcb_pkg::CHANNEL_FIELD_MASK;
		end
		if (wr_sup) begin
			suppress_next = REG_REQ.wdata & fmrcb_pkg::FULL_FIELD_MASK;
		end
		if (wr_open) begin
			open_en_next = REG_REQ.wdata & fmrcb_pkg::CHANNEL_FIELD_MASK;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rev_block_reg <= fmrcb_pkg::REVERSE_BLOCK_GATE_CONFIG_RST;
			suppress_reg  <= fmrcb_pkg::FAULT_PIN_SUPPRESS_CONFIG_RST;
			open_en_reg   <= fmrcb_pkg::OFFSTATE_OPEN_LOAD_ENABLE_RST;
		end else begin
			rev_block_reg <= rev_block_next;
			suppress_reg  <= suppress_next;
			open_en_reg   <= open_en_next;
		end
	end

	// ************************************************************
	// fault-type status, cleared by reading it
	// ************************************************************
	fmrcb_pkg::fmrcb_fault_s fault_cond;
	logic [fmrcb_pkg::NUM_FLT-1:0] fault_vec;
	logic [fmrcb_pkg::NUM_FLT-1:0] status_flag;
	logic                          status_rd;

	assign status_rd = REG_REQ.rd && (REG_REQ.addr == fmrcb_pkg::FAULT_TYPE_STATUS_OFS);

	always_comb begin
		fault_cond = FAULT_RAW;
		// disabled channels never reach the status register
		fault_cond.offstate_open = |(OFFSTATE_OPEN_RAW & open_en_reg[fmrcb_pkg::NUM_CH-1:0]);
	end

	assign fault_vec = fault_cond;

	genvar g;
	generate
		for (g = 0; g < fmrcb_pkg::NUM_FLT; g++) begin : g_flag
			fmrcb_sticky_flag u_flag (
				.clk       (CLK_SYS),
				.rst_n     (NRST),
				.cond      (fault_vec[g]),
				.clr       (status_rd),
				.latch_dis (FAULT_LATCH_DISABLE),
				.flag      (status_flag[g])
			);
		end
	endgenerate

	// ************************************************************
	// fault pin and channel controls
	// ************************************************************
	logic [fmrcb_pkg::NUM_FLT-1:0] pin_src;
	logic                          fault_pin_next;
	logic                          fault_pin_reg;
	logic [fmrcb_pkg::NUM_CH-1:0]  rcb_en_next;
	logic [fmrcb_pkg::NUM_CH-1:0]  rcb_pd_next;
	logic [fmrcb_pkg::NUM_CH-1:0]  rcb_en_reg;
	logic [fmrcb_pkg::NUM_CH-1:0]  rcb_pd_reg;
	logic [fmrcb_pkg::NUM_CH-1:0]  open_diag_reg;
	logic                          fault_pin_o_reg;

	always_comb begin
		// masked faults still sit in status, only the pin is spared
		pin_src[fmrcb_pkg::BIT_SPI_ERR]   = status_flag[fmrcb_pkg::BIT_SPI_ERR]
			& ~suppress_reg[fmrcb_pkg::BIT_SPI_ERR];
		pin_src[fmrcb_pkg::BIT_WATCHDOG_TIMEOUT_ERROR]    = status_flag[fmrcb_pkg::BIT_WATCHDOG_TIMEOUT_ERROR]
			& ~suppress_reg[fmrcb_pkg::BIT_WATCHDOG_TIMEOUT_ERROR];
		pin_src[fmrcb_pkg::BIT_ILIMIT]    = status_flag[fmrcb_pkg::BIT_ILIMIT]
			& ~suppress_reg[fmrcb_pkg::BIT_ILIMIT];
		pin_src[fmrcb_pkg::BIT_REVERSE]   = status_flag[fmrcb_pkg::BIT_REVERSE]
			& ~suppress_reg[fmrcb_pkg::BIT_REVERSE];
		pin_src[fmrcb_pkg::BIT_SHORT_VS]  = status_flag[fmrcb_pkg::BIT_SHORT_VS]
			& ~suppress_reg[fmrcb_pkg::BIT_SHORT_VS];
		pin_src[fmrcb_pkg::BIT_WB_OFF]    = status_flag[fmrcb_pkg::BIT_WB_OFF]
			& ~suppress_reg[fmrcb_pkg::BIT_WB_OFF];
		pin_src[fmrcb_pkg::BIT_WB_ON]     = status_flag[fmrcb_pkg::BIT_WB_ON]
			& ~suppress_reg[fmrcb_pkg::BIT_WB_ON];
		pin_src[fmrcb_pkg::BIT_UNDERVOLT] = status_flag[fmrcb_pkg::BIT_UNDERVOLT]
			& ~suppress_reg[fmrcb_pkg::BIT_UNDERVOLT];
		fault_pin_next = |pin_src;
		// global disable drops both gate modes on every channel
		if (GLOBAL_REV_BLOCK_DISABLE) begin
			rcb_en_next = '0;
			rcb_pd_next = '0;
		end else begin
			rcb_en_next = rev_block_reg[fmrcb_pkg::NUM_CH-1:0];
			rcb_pd_next = ~rev_block_reg[fmrcb_pkg::NUM_CH-1:0];
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			fault_pin_reg <= 1'b0;
			rcb_en_reg    <= '0;
			rcb_pd_reg    <= '0;
			open_diag_reg <= '0;
			fault_pin_o_reg <= 1'b0;
		end else begin
			fault_pin_reg <= fault_pin_next;
			rcb_en_reg    <= rcb_en_next;
			rcb_pd_reg    <= rcb_pd_next;
			open_diag_reg <= open_en_reg[fmrcb_pkg::NUM_CH-1:0];
			// held low, only the enable moves the pad
			fault_pin_o_reg <= 1'b0;
		end
	end

	// ************************************************************
	// read port
	// ************************************************************
	fmrcb_pkg::fmrcb_rsp_s rsp_reg;
	fmrcb_pkg::fmrcb_rsp_s rsp_next;

	always_comb begin
		// rdata idles at zero, so a stray sample reads nothing
		rsp_next.valid = REG_REQ.rd;
		rsp_next.rdata = fmrcb_pkg::READ_ZERO;
		if (REG_REQ.rd) begin
			case (REG_REQ.addr)
				fmrcb_pkg::REVERSE_BLOCK_GATE_CONFIG_OFS: begin
					rsp_next.rdata = rev_block_reg & fmrcb_pkg::CHANNEL_FIELD_MASK;
				end
				fmrcb_pkg::FAULT_PIN_SUPPRESS_CONFIG_OFS: begin
					rsp_next.rdata = suppress_reg;
				end
				fmrcb_pkg::OFFSTATE_OPEN_LOAD_ENABLE_OFS: begin
					rsp_next.rdata = open_en_reg & fmrcb_pkg::CHANNEL_FIELD_MASK;
				end
				fmrcb_pkg::FAULT_TYPE_STATUS_OFS: begin
					rsp_next.rdata = status_flag;
				end
				default: begin
					rsp_next.rdata = fmrcb_pkg::READ_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg <= rsp_next;
		end
	end

	assign REG_RSP                = rsp_reg;
	assign REV_BLOCK_ENABLE       = rcb_en_reg;
	assign REV_BLOCK_PULLDOWN     = rcb_pd_reg;
	assign OFFSTATE_OPEN_DIAG_EN  = open_diag_reg;
	// open drain: the pad only ever pulls low
	assign FAULT_INDICATOR_PIN_O  = fault_pin_o_reg;
	assign FAULT_INDICATOR_PIN_OE = fault_pin_reg;

endmodule

`default_nettype wire

// ===== tb/fmrcb_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// port checks
// ****
module fmrcb_regs_chk (
	input wire logic                    CLK_SYS,
	input wire logic                    NRST,
	input wire fmrcb_pkg::fmrcb_req_s   REG_REQ,
	input wire fmrcb_pkg::fmrcb_rsp_s   REG_RSP,
	input wire logic                    GLOBAL_REV_BLOCK_DISABLE,
	input wire logic                    FAULT_LATCH_DISABLE,
	input wire fmrcb_pkg::fmrcb_fault_s FAULT_RAW,
	input wire logic [3:0]              OFFSTATE_OPEN_RAW,
	input wire logic [3:0]              REV_BLOCK_ENABLE,
	input wire logic [3:0]              REV_BLOCK_PULLDOWN,
	input wire logic [3:0]              OFFSTATE_OPEN_DIAG_EN,
	input wire logic                    FAULT_INDICATOR_PIN_OE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	// no raw fault of any kind
	wire logic quiet = FAULT_RAW == 8'h00 && OFFSTATE_OPEN_RAW == 4'h0;
	a_rsp_idle: assert property (
		!$past(REG_REQ.rd) |-> REG_RSP == 9'h000) else $error("stray response");
	a_upper_zero: assert property (
		REG_RSP.valid && $past(REG_REQ.addr) inside {8'h26, 8'h28}
		|-> REG_RSP.rdata[7:4] == 4'h0) else $error("reserved bits set");
	a_block_split: assert property (
		$past(NRST) && !$past(GLOBAL_REV_BLOCK_DISABLE)
		|-> (REV_BLOCK_ENABLE ^ REV_BLOCK_PULLDOWN) == 4'hf) else $error("gate split");
	a_block_off: assert property (
		$past(GLOBAL_REV_BLOCK_DISABLE)
		|-> (REV_BLOCK_ENABLE | REV_BLOCK_PULLDOWN) == 4'h0) else $error("gate not off");
	a_block_reset: assert property (
		!$past(NRST) && !GLOBAL_REV_BLOCK_DISABLE
		|=> REV_BLOCK_ENABLE == 4'hf) else $error("blocking not on");
	a_diag_copy: assert property (
		REG_REQ.wr && REG_REQ.addr == 8'h28 ##1 !REG_REQ.wr
		|=> OFFSTATE_OPEN_DIAG_EN == $past(REG_REQ.wdata[3:0], 2)) else $error("diag");
	a_read_clears: assert property (
		REG_REQ.rd && REG_REQ.addr == 8'h10 && quiet ##1 quiet [*2]
		|-> !FAULT_INDICATOR_PIN_OE) else $error("pin held after read");
	a_follow_raw: assert property (
		(FAULT_LATCH_DISABLE && quiet) [*3]
		|-> !FAULT_INDICATOR_PIN_OE) else $error("pin held");
	c_read: cover property (REG_RSP.valid);
	c_pin: cover property ($rose(FAULT_INDICATOR_PIN_OE));
	c_clear: cover property ($fell(FAULT_INDICATOR_PIN_OE) && !FAULT_LATCH_DISABLE);
endmodule
bind fmrcb_regs fmrcb_regs_chk i_chk (.*);
`default_nettype wire

// ===== tb/fmrcb_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// host side
// ****
module fmrcb_host (
	input  wire logic                  clk,
	input  wire fmrcb_pkg::fmrcb_rsp_s rsp,
	output var  fmrcb_pkg::fmrcb_req_s req
);
	initial req = '0;
	// idle bus shows junk, not the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = {2'b10, a, d};
		@(negedge clk);
		req = {2'b00, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		req = {2'b01, a, ~a};
		// answer stands only in the cycle after the taking edge
		@(negedge clk);
		d = rsp.valid ? rsp.rdata : 8'hxx;
		req = {2'b00, ~a, a};
	endtask
endmodule
`default_nettype wire

// ===== tb/fmrcb_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// bench
// ****
module fmrcb_regs_tb;
	logic                  clk, nrst, glob, ldis, pin_o, pin_oe;
	logic [7:0]            raw, a, d, m;
	logic [3:0]            oraw, en, pd, diag;
	fmrcb_pkg::fmrcb_req_s req;
	fmrcb_pkg::fmrcb_rsp_s rsp;
	int                    errors, check_count, seed, i, b;
	fmrcb_host i_host (.clk(clk), .rsp(rsp), .req(req));
	fmrcb_regs i_dut (.CLK_SYS(clk), .NRST(nrst), .REG_REQ(req), .REG_RSP(rsp),
		.GLOBAL_REV_BLOCK_DISABLE(glob), .FAULT_LATCH_DISABLE(ldis), .FAULT_RAW(raw),
		.OFFSTATE_OPEN_RAW(oraw), .REV_BLOCK_ENABLE(en), .REV_BLOCK_PULLDOWN(pd),
		.OFFSTATE_OPEN_DIAG_EN(diag), .FAULT_INDICATOR_PIN_O(pin_o),
		.FAULT_INDICATOR_PIN_OE(pin_oe));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] ra, input logic [7:0] e);
		logic [7:0] v;
		i_host.rd(ra, v);
		chk("read", e, v);
	endtask
	function automatic logic [7:0] exp_rd(logic [7:0] ra, logic [7:0] v);
		return ra inside {8'h26, 8'h28} ? v & 8'h0f : (ra == 8'h27 ? v : 8'h00);
	endfunction
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		test_done;
	end
	initial begin
		seed = 60722;
		{nrst, glob, ldis, raw, oraw} = '0;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		chk("gate", 8'hf0, {en, pd});
		rdc(8'h26, 8'h0f);
		rdc(8'h27, 8'h00);
		rdc(8'h28, 8'h00);
		i_host.wr(8'h26, 8'hf0);
		rdc(8'h26, 8'h00);
		for (i = 0; i < 40; i++) begin
			m = $random(seed);
			b = i % 4;
			a = (b == 3) ? {1'b1, m[6:0]} : 8'h26 + 8'(b);
			m = $random(seed);
			glob = m[7] & m[6];
			i_host.wr(a, m);
			rdc(a, exp_rd(a, m));
			if (b == 0) chk("gate", glob ? 8'h00 : {m[3:0], ~m[3:0]}, {en, pd});
			if (b == 2) chk("diag", {4'h0, m[3:0]}, {4'h0, diag});
		end
		glob = 1'b0;
		i_host.wr(8'h28, 8'h0f);
		for (i = 0; i < 16; i++) begin
			b = i % 8;
			m = $random(seed);
			m[b] = (i >= 8);
			i_host.wr(8'h27, m);
			oraw[m[1:0]] = (b == 2);
			raw[b] = (b != 2);
			repeat (3) @(negedge clk);
			chk("pin", {7'h00, ~m[b]}, {7'h00, pin_oe});
			chk("pin_o", 8'h00, {7'h00, pin_o});
			{raw, oraw} = '0;
			@(negedge clk);
			rdc(8'h10, 8'h01 << b);
			@(negedge clk);
			chk("pin", 8'h00, {7'h00, pin_oe});
		end
		i_host.wr(8'h27, 8'h00);
		raw = 8'h20;
		@(negedge clk);
		raw = 8'h00;
		repeat (5) @(negedge clk);
		chk("pin", 8'h01, {7'h00, pin_oe});
		rdc(8'h10, 8'h20);
		ldis = 1'b1;
		raw = 8'h01;
		repeat (3) @(negedge clk);
		chk("pin", 8'h01, {7'h00, pin_oe});
		raw = 8'h00;
		repeat (3) @(negedge clk);
		chk("pin", 8'h00, {7'h00, pin_oe});
		i_host.wr(8'h28, 8'h0e);
		oraw = 4'h1;
		repeat (3) @(negedge clk);
		rdc(8'h10, 8'h00);
		ldis = 1'b0;
		oraw = 4'h0;
		i_host.wr(8'h26, 8'h05);
		i_host.wr(8'h27, 8'hff);
		raw = 8'h02;
		@(negedge clk);
		raw = 8'h00;
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		chk("reset", 8'h00, {en, pd});
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		chk("gate", 8'hf0, {en, pd});
		chk("pin", 8'h00, {7'h00, pin_oe});
		rdc(8'h26, 8'h0f);
		rdc(8'h27, 8'h00);
		rdc(8'h28, 8'h00);
		rdc(8'h10, 8'h00);
		test_done;
	end
endmodule
`default_nettype wire
